// ---- rtl/snce_pkg.sv ----
// serial nand command engine: shared constants and types
package snce_pkg;
	// ==========================================================
	// timing
	localparam int CLK_NS     = 25;
	localparam int T_LOAD_NS  = 25000;
	localparam int T_PROG_NS  = 300000;
	localparam int T_ERASE_NS = 3000000;
	localparam int T_RST_NS   = 5000;
	localparam int LOAD_CYC   = (T_LOAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC   = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC  = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RST_CYC    = (T_RST_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUSY_W     = 17;
	// ==========================================================
	// opcodes
	localparam logic [7:0] CMD_WLS   = 8'h06;
	localparam logic [7:0] CMD_WLC   = 8'h04;
	localparam logic [7:0] CMD_FGET  = 8'h0f;
	localparam logic [7:0] CMD_FSET  = 8'h1f;
	localparam logic [7:0] CMD_PREAD = 8'h13;
	localparam logic [7:0] CMD_RDC   = 8'h03;
	localparam logic [7:0] CMD_RDCF  = 8'h0b;
	localparam logic [7:0] CMD_RDC2  = 8'h3b;
	localparam logic [7:0] CMD_RDC4  = 8'h6b;
	localparam logic [7:0] CMD_RDCD  = 8'hbb;
	localparam logic [7:0] CMD_RDCQ  = 8'heb;
	localparam logic [7:0] CMD_ID    = 8'h9f;
	localparam logic [7:0] CMD_UID   = 8'h4b;
	localparam logic [7:0] CMD_PLD   = 8'h02;
	localparam logic [7:0] CMD_PLD4  = 8'h32;
	localparam logic [7:0] CMD_PLR   = 8'h84;
	localparam logic [7:0] CMD_PLR4  = 8'hc4;
	localparam logic [7:0] CMD_PLR4B = 8'h34;
	localparam logic [7:0] CMD_PLRQ  = 8'h72;
	localparam logic [7:0] CMD_PEXE  = 8'h10;
	localparam logic [7:0] CMD_ERASE = 8'hd8;
	localparam logic [7:0] CMD_RST   = 8'hff;
	localparam logic [7:0] CMD_LOCK  = 8'h36;
	localparam logic [7:0] CMD_UNLK  = 8'h39;
	localparam logic [7:0] CMD_LRD   = 8'h3d;
	localparam logic [7:0] CMD_GLK   = 8'h7e;
	localparam logic [7:0] CMD_GUL   = 8'h98;
	// ==========================================================
	// feature registers
	localparam logic [7:0] FA_ECC    = 8'h90;
	localparam logic [7:0] FA_LOCK   = 8'ha0;
	localparam logic [7:0] FA_FEAT   = 8'hb0;
	localparam logic [7:0] FA_STAT   = 8'hc0;
	localparam logic [7:0] ECC_MASK  = 8'h10;
	localparam logic [7:0] LOCK_MASK = 8'hbe;
	localparam logic [7:0] PROT_MASK = 8'h3e;
	localparam logic [7:0] FEAT_MASK = 8'he1;
	localparam logic [7:0] ECC_RST   = 8'h10;
	localparam logic [7:0] LOCK_RST  = 8'h00;
	localparam logic [7:0] FEAT_RST  = 8'h00;
	localparam int GUARD_BIT = 7;
	localparam int SEAL_BIT  = 7;
	localparam int QUAD_BIT  = 0;
	localparam int ST_BUSY   = 0;
	localparam int ST_LATCH  = 1;
	// ==========================================================
	// cache
	localparam int          CACHE_BYTES = 2176;
	localparam logic [11:0] COL_LAST    = 12'h87f;
	localparam logic [11:0] MSK_2K      = 12'h7ff;
	localparam logic [11:0] MSK_64      = 12'h03f;
	localparam logic [11:0] MSK_16      = 12'h00f;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		S_OP, S_ADDR, S_DUMMY, S_DIN, S_DOUT, S_IGN
	} snce_state_e;
	typedef enum logic [2:0] {
		J_NONE, J_LOAD, J_PROG, J_ERASE, J_RST
	} snce_job_e;
	typedef enum logic [2:0] {
		O_FEAT, O_CACHE, O_ID, O_UID, O_ZERO
	} snce_src_e;
	typedef struct packed {
		logic      ok;
		logic [1:0] nadr;
		logic [2:0] ndum;
		logic [2:0] alan;
		logic [2:0] dlan;
		logic      out;
		logic      inp;
		snce_src_e src;
	} snce_dec_s;
endpackage

// ---- rtl/snce_if.sv ----
// serial nand command engine: synchronised link signals
`timescale 1ns/1ps
`default_nettype none
interface snce_if;
	logic       sck_rise;
	logic       sck_fall;
	logic       sel;
	logic [3:0] din;
	modport src (output sck_rise, sck_fall, sel, din);
	modport snk (input sck_rise, sck_fall, sel, din);
endinterface
`default_nettype wire

// ---- rtl/snce_sync.sv ----
// serial nand command engine: pin synchroniser and clock edge finder
`timescale 1ns/1ps
`default_nettype none
module snce_sync (
	// system
	input  wire logic       clk,
	input  wire logic       rst_n,
	// pins
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic [3:0] io_in,
	// synchronised side
	snce_if.src             lk
);
	logic [5:0] meta;
	logic [5:0] stab;
	logic       sck_d;

	// ==========================================================
	// two flops per pin, then one more for the link clock edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta  <= 6'h00;
			stab  <= 6'h00;
			sck_d <= 1'b0;
		end else begin
			meta  <= {sck, ~cs_n, io_in};
			stab  <= meta;
			sck_d <= stab[5];
		end
	end

	// edges and levels for the engine
	assign lk.sck_rise = stab[5] & ~sck_d;
	assign lk.sck_fall = ~stab[5] & sck_d;
	assign lk.sel      = stab[4];
	assign lk.din      = stab[3:0];
endmodule
`default_nettype wire

// ---- rtl/snce_top.sv ----
// serial nand command engine: opcode decoder, features, cache, busy timer
`timescale 1ns/1ps
`default_nettype none
module snce_top #(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
	parameter logic [7:0] PART_CODE  = 8'h3c, // arbitrary value
	parameter logic [7:0] UID_BYTE   = 8'h96, // arbitrary value
	parameter int         PROG_CYC   = snce_pkg::PROG_CYC,
	parameter int         ERASE_CYC  = snce_pkg::ERASE_CYC
) (
	// system
	input  wire logic        clk,
	input  wire logic        rst_n,
	// serial link pins
	input  wire logic        sck,
	input  wire logic        cs_n,
	input  wire logic [3:0]  io_in,
	output logic      [3:0]  io_out,
	output logic      [3:0]  io_oe,
	// array side
	output logic      [16:0] row_address,
	// nonvolatile seal store
	input  wire logic        otp_seal_stored,
	output logic             otp_seal
);
	localparam int BW = snce_pkg::BUSY_W;

	snce_if lk ();

	snce_sync u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.sck   (sck),
		.cs_n  (cs_n),
		.io_in (io_in),
		.lk    (lk.src)
	);

	snce_pkg::snce_state_e state;
	snce_pkg::snce_job_e   job;
	snce_pkg::snce_dec_s   d;
	snce_pkg::snce_dec_s   dec;
	logic [7:0]            op;
	logic [7:0]            sr;
	logic [7:0]            osh;
	logic [23:0]           addr;
	logic [2:0]            bcnt;
	logic [2:0]            nleft;
	logic [2:0]            lanes_in;
	logic [2:0]            ocnt;
	logic [11:0]           col;
	logic [3:0]            wrap;
	logic                  id_sel;
	logic                  write_latch;
	logic                  seal_init;
	logic [7:0]            ecc_cfg;
	logic [7:0]            lock_cfg;
	logic [7:0]            feat_cfg;
	logic [BW-1:0]         busy_cnt;
	logic [7:0]            cache [snce_pkg::CACHE_BYTES];

	// ==========================================================
	// opcode table
	function automatic snce_pkg::snce_dec_s decode(
		input logic [7:0] c,
		input logic       q
	);
		snce_pkg::snce_dec_s r;
		r = '{ok: 1'b1, nadr: 2'd0, ndum: 3'd0, alan: 3'd1, dlan: 3'd1,
			out: 1'b0, inp: 1'b0, src: snce_pkg::O_ZERO};
		case (c)
			snce_pkg::CMD_WLS, snce_pkg::CMD_WLC, snce_pkg::CMD_RST,
			snce_pkg::CMD_GLK, snce_pkg::CMD_GUL: begin
				r.ok = 1'b1;
			end
			snce_pkg::CMD_FGET: begin
				r.nadr = 2'd1;
				r.out  = 1'b1;
				r.src  = snce_pkg::O_FEAT;
			end
			snce_pkg::CMD_FSET: begin
				r.nadr = 2'd1;
				r.inp  = 1'b1;
			end
			snce_pkg::CMD_PREAD, snce_pkg::CMD_PEXE, snce_pkg::CMD_ERASE,
			snce_pkg::CMD_LOCK, snce_pkg::CMD_UNLK: begin
				r.nadr = 2'd3;
			end
			snce_pkg::CMD_LRD: begin
				r.nadr = 2'd3;
				r.out  = 1'b1;
			end
			snce_pkg::CMD_RDC, snce_pkg::CMD_RDCF, snce_pkg::CMD_RDC2,
			snce_pkg::CMD_RDC4, snce_pkg::CMD_RDCD,
			snce_pkg::CMD_RDCQ: begin
				r.nadr = 2'd2;
				r.ndum = 3'd1;
				r.out  = 1'b1;
				r.src  = snce_pkg::O_CACHE;
				if (c == snce_pkg::CMD_RDC2 || c == snce_pkg::CMD_RDCD)
					r.dlan = 3'd2;
				if (c == snce_pkg::CMD_RDC4 || c == snce_pkg::CMD_RDCQ)
					r.dlan = 3'd4;
				if (c == snce_pkg::CMD_RDCD || c == snce_pkg::CMD_RDCQ)
					r.alan = r.dlan;
				if (c == snce_pkg::CMD_RDC4 || c == snce_pkg::CMD_RDCQ)
					r.ok = q;
			end
			snce_pkg::CMD_ID, snce_pkg::CMD_UID: begin
				r.ndum = (c == snce_pkg::CMD_ID) ? 3'd1 : 3'd4;
				r.out  = 1'b1;
				r.src  = (c == snce_pkg::CMD_ID) ? snce_pkg::O_ID
					: snce_pkg::O_UID;
			end
			snce_pkg::CMD_PLD, snce_pkg::CMD_PLR: begin
				r.nadr = 2'd2;
				r.inp  = 1'b1;
			end
			snce_pkg::CMD_PLD4, snce_pkg::CMD_PLR4, snce_pkg::CMD_PLR4B,
			snce_pkg::CMD_PLRQ: begin
				r.nadr = 2'd2;
				r.inp  = 1'b1;
				r.dlan = 3'd4;
				r.alan = (c == snce_pkg::CMD_PLRQ) ? 3'd4 : 3'd1;
				r.ok   = q;
			end
			default: begin
				r.ok = 1'b0;
			end
		endcase
		return r;
	endfunction

	// ==========================================================
	// input shifting and phase events
	wire logic        quad     = feat_cfg[snce_pkg::QUAD_BIT];
	wire logic [3:0]  bsum     = {1'b0, bcnt} + {1'b0, lanes_in};
	wire logic        in_rise  = lk.sck_rise && lk.sel
		&& state != snce_pkg::S_DOUT && state != snce_pkg::S_IGN;
	wire logic        byte_done = in_rise && bsum[3];
	wire logic [7:0]  new_byte = (lanes_in == 3'd4) ? {sr[3:0], lk.din}
		: (lanes_in == 3'd2) ? {sr[5:0], lk.din[1:0]}
		: {sr[6:0], lk.din[0]};
	wire logic [23:0] a_full   = {addr[15:0], new_byte};
	wire logic        op_done  = byte_done && state == snce_pkg::S_OP;
	wire logic        adr_done = byte_done && state == snce_pkg::S_ADDR
		&& nleft == 3'd1;
	wire logic        din_done = byte_done && state == snce_pkg::S_DIN;
	wire logic        fset     = din_done && op == snce_pkg::CMD_FSET;
	wire logic        wr_cache = din_done && op != snce_pkg::CMD_FSET;
	wire logic        guard    = lock_cfg[snce_pkg::GUARD_BIT]
		&& !lk.din[2] && !quad;
	wire logic        is_lock  = op == snce_pkg::CMD_LOCK
		|| op == snce_pkg::CMD_UNLK || op == snce_pkg::CMD_LRD;

	// next state once address bytes are in
	wire snce_pkg::snce_state_e nx_data = d.out ? snce_pkg::S_DOUT
		: d.inp ? snce_pkg::S_DIN : snce_pkg::S_IGN;

	// busy timer events
	wire logic busy        = job != snce_pkg::J_NONE;
	wire logic job_end     = busy && busy_cnt == '0;
	wire logic start_load  = adr_done && op == snce_pkg::CMD_PREAD;
	wire logic start_prog  = adr_done && op == snce_pkg::CMD_PEXE
		&& write_latch;
	wire logic start_erase = adr_done && op == snce_pkg::CMD_ERASE
		&& write_latch;
	wire logic start_rst   = op_done && new_byte == snce_pkg::CMD_RST;
	wire logic latch_set   = op_done && new_byte == snce_pkg::CMD_WLS;
	wire logic latch_clr   = (op_done && new_byte == snce_pkg::CMD_WLC)
		|| (job_end && (job == snce_pkg::J_PROG
		|| job == snce_pkg::J_ERASE));

	// status and feature read selection
	wire logic [7:0] status = (8'(write_latch) << snce_pkg::ST_LATCH)
		| (8'(busy) << snce_pkg::ST_BUSY);
	wire logic [7:0] feat_byte = (addr[7:0] == snce_pkg::FA_ECC) ? ecc_cfg
		: (addr[7:0] == snce_pkg::FA_LOCK) ? lock_cfg
		: (addr[7:0] == snce_pkg::FA_FEAT) ? feat_cfg
		: (addr[7:0] == snce_pkg::FA_STAT) ? status : 8'h00;
	wire logic [7:0] src_byte = (d.src == snce_pkg::O_FEAT) ? feat_byte
		: (d.src == snce_pkg::O_CACHE) ? cache[col]
		: (d.src == snce_pkg::O_ID) ? (id_sel ? PART_CODE : MAKER_CODE)
		: (d.src == snce_pkg::O_UID) ? UID_BYTE : 8'h00;

	// wrap region column advance
	wire logic [11:0] col_inc = col + 12'h001;
	wire logic [11:0] wmask   = (wrap[3:2] == 2'b01) ? snce_pkg::MSK_2K
		: (wrap[3:2] == 2'b10) ? snce_pkg::MSK_64
		: snce_pkg::MSK_16;
	wire logic [11:0] col_nx  = (wrap[3:2] == 2'b00)
		? ((col == snce_pkg::COL_LAST) ? 12'h000 : col_inc)
		: ((col & ~wmask) | (col_inc & wmask));

	// output lane shaping
	wire logic       fetch    = lk.sck_fall && lk.sel
		&& state == snce_pkg::S_DOUT && ocnt == 3'd0;
	wire logic [7:0] cur      = (ocnt == 3'd0) ? src_byte : osh;
	wire logic [3:0] out_bits = (d.dlan == 3'd4) ? cur[7:4]
		: (d.dlan == 3'd2) ? {2'b00, cur[7:6]}
		: {2'b00, cur[7], 1'b0};
	wire logic [3:0] oe_pat   = (d.dlan == 3'd4) ? 4'hf
		: (d.dlan == 3'd2) ? 4'h3 : 4'h2;

	assign dec      = decode(new_byte, quad);
	assign otp_seal = feat_cfg[snce_pkg::SEAL_BIT];

	// ==========================================================
	// command sequencer, restarts at each chip select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= snce_pkg::S_OP;
			op       <= 8'h00;
			d        <= '0;
			sr       <= 8'h00;
			addr     <= 24'h000000;
			bcnt     <= 3'd0;
			nleft    <= 3'd0;
			lanes_in <= 3'd1;
		end else if (!lk.sel) begin
			state    <= snce_pkg::S_OP;
			bcnt     <= 3'd0;
			lanes_in <= 3'd1;
		end else if (in_rise) begin
			sr   <= new_byte;
			bcnt <= bsum[2:0];
			if (byte_done) begin
				case (state)
					snce_pkg::S_OP: begin
						op       <= new_byte;
						d        <= dec;
						lanes_in <= dec.alan;
						nleft    <= (dec.nadr != 2'd0) ? {1'b0, dec.nadr}
							: dec.ndum;
						if (!dec.ok)
							state <= snce_pkg::S_IGN;
						else if (dec.nadr != 2'd0)
							state <= snce_pkg::S_ADDR;
						else if (dec.ndum != 3'd0)
							state <= snce_pkg::S_DUMMY;
						else
							state <= snce_pkg::S_IGN;
					end
					snce_pkg::S_ADDR: begin
						addr  <= a_full;
						nleft <= nleft - 3'd1;
						if (nleft == 3'd1) begin
							nleft <= d.ndum;
							if (d.inp)
								lanes_in <= d.dlan;
							if (d.ndum != 3'd0)
								state <= snce_pkg::S_DUMMY;
							else if (is_lock && a_full[23])
								state <= snce_pkg::S_IGN;
							else
								state <= nx_data;
						end
					end
					snce_pkg::S_DUMMY: begin
						nleft <= nleft - 3'd1;
						if (nleft == 3'd1)
							state <= snce_pkg::S_DOUT;
					end
					snce_pkg::S_DIN: begin
						if (op == snce_pkg::CMD_FSET)
							state <= snce_pkg::S_IGN;
					end
					default: begin
						state <= snce_pkg::S_IGN;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// output shifter, changes only after a falling link clock edge or at deselect
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_out <= 4'h0;
			io_oe  <= 4'h0;
			osh    <= 8'h00;
			ocnt   <= 3'd0;
			id_sel <= 1'b0;
		end else if (!lk.sel) begin
			io_oe  <= 4'h0;
			ocnt   <= 3'd0;
			id_sel <= 1'b0;
		end else if (lk.sck_fall && state == snce_pkg::S_DOUT) begin
			io_out <= out_bits;
			io_oe  <= oe_pat;
			osh    <= cur << d.dlan;
			ocnt   <= ocnt + d.dlan;
			if (fetch && d.src == snce_pkg::O_ID)
				id_sel <= ~id_sel;
		end
	end

	// column pointer and wrap mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			col  <= 12'h000;
			wrap <= 4'h0;
		end else if (adr_done) begin
			col  <= a_full[11:0];
			wrap <= (d.src == snce_pkg::O_CACHE) ? a_full[15:12] : 4'h0;
		end else if (wr_cache || (fetch && d.src == snce_pkg::O_CACHE)) begin
			col <= col_nx;
		end
	end

	// cache store for program loads
	always_ff @(posedge clk) begin
		if (wr_cache)
			cache[col] <= new_byte;
	end

	// row address handed to the array
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			row_address <= 17'h00000;
		else if (adr_done && is_lock && !a_full[23])
			row_address <= {a_full[22:12], 6'h00};
		else if (adr_done && !is_lock && d.nadr == 2'd3)
			row_address <= a_full[16:0];
	end

	// ==========================================================
	// feature registers, untouched by the reset opcode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ecc_cfg   <= snce_pkg::ECC_RST;
			lock_cfg  <= snce_pkg::LOCK_RST;
			feat_cfg  <= snce_pkg::FEAT_RST;
			seal_init <= 1'b0;
		end else if (!seal_init) begin
			seal_init <= 1'b1;
			feat_cfg[snce_pkg::SEAL_BIT] <= otp_seal_stored;
		end else if (fset) begin
			case (addr[7:0])
				snce_pkg::FA_ECC:
					ecc_cfg <= new_byte & snce_pkg::ECC_MASK;
				snce_pkg::FA_LOCK:
					lock_cfg <= guard
						? ((new_byte & snce_pkg::LOCK_MASK & ~snce_pkg::PROT_MASK)
						| (lock_cfg & snce_pkg::PROT_MASK))
						: (new_byte & snce_pkg::LOCK_MASK);
				snce_pkg::FA_FEAT:
					feat_cfg <= (new_byte & snce_pkg::FEAT_MASK)
						| (feat_cfg & (8'h01 << snce_pkg::SEAL_BIT));
				default:
					ecc_cfg <= ecc_cfg;
			endcase
		end
	end

	// busy timer, power-up page load first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			job      <= snce_pkg::J_LOAD;
			busy_cnt <= BW'(snce_pkg::LOAD_CYC - 1);
		end else if (start_load) begin
			job      <= snce_pkg::J_LOAD;
			busy_cnt <= BW'(snce_pkg::LOAD_CYC - 1);
		end else if (start_prog) begin
			job      <= snce_pkg::J_PROG;
			busy_cnt <= BW'(PROG_CYC - 1);
		end else if (start_erase) begin
			job      <= snce_pkg::J_ERASE;
			busy_cnt <= BW'(ERASE_CYC - 1);
		end else if (start_rst) begin
			job      <= snce_pkg::J_RST;
			busy_cnt <= BW'(snce_pkg::RST_CYC - 1);
		end else if (job_end) begin
			job <= snce_pkg::J_NONE;
		end else if (busy) begin
			busy_cnt <= busy_cnt - 1'b1;
		end
	end

	// write latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			write_latch <= 1'b0;
		else if (latch_set)
			write_latch <= 1'b1;
		else if (latch_clr)
			write_latch <= 1'b0;
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_latch_set;
		latch_set |=> write_latch ##1 write_latch || latch_clr;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch set");

	property p_latch_clr;
		op_done && new_byte == snce_pkg::CMD_WLC |=> !write_latch;
	endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latch clr");

	property p_exec_guard;
		$rose(job == snce_pkg::J_PROG || job == snce_pkg::J_ERASE)
			|-> $past(write_latch);
	endproperty
	a_exec_guard: assert property (p_exec_guard) else $error("no latch");

	property p_auto_clear;
		job_end && job != snce_pkg::J_LOAD && job != snce_pkg::J_RST
			|=> !write_latch && !busy;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("latch kept");

	property p_status_ro;
		fset && addr[7:0] == snce_pkg::FA_STAT |=> $stable(write_latch);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status wr");

	property p_guard;
		fset && addr[7:0] == snce_pkg::FA_LOCK && guard
			|=> (lock_cfg & snce_pkg::PROT_MASK)
			== ($past(lock_cfg) & snce_pkg::PROT_MASK);
	endproperty
	a_guard: assert property (p_guard) else $error("guard broken");

	property p_quad;
		op_done && !quad && (new_byte == snce_pkg::CMD_RDC4
			|| new_byte == snce_pkg::CMD_RDCQ) |=> state == snce_pkg::S_IGN;
	endproperty
	a_quad: assert property (p_quad) else $error("quad taken");

	property p_load_busy;
		start_load |=> job == snce_pkg::J_LOAD [*8];
	endproperty
	a_load_busy: assert property (p_load_busy) else $error("no busy");

	property p_wrap_full;
		fetch && d.src == snce_pkg::O_CACHE && wrap[3:2] == 2'b00
			&& col == snce_pkg::COL_LAST |=> col == 12'h000;
	endproperty
	a_wrap_full: assert property (p_wrap_full) else $error("no wrap");

	property p_wrap16;
		fetch && d.src == snce_pkg::O_CACHE && wrap[3:2] == 2'b11
			|=> col[11:4] == $past(col[11:4]);
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("wrap 16");

	property p_out_fall;
		!$stable(io_out) |-> $past(lk.sck_fall);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("out edge");

	property p_ignore;
		state == snce_pkg::S_IGN && lk.sel |=> state == snce_pkg::S_IGN;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignore left");

	c_fget: cover property (fset ##[1:200] state == snce_pkg::S_DOUT);
	c_quad: cover property (fetch && d.dlan == 3'd4);
	c_prog: cover property (job == snce_pkg::J_PROG ##1 job_end);
	c_id:   cover property (fetch && d.src == snce_pkg::O_ID && id_sel);
endmodule
`default_nettype wire

// ---- bench/snce_host.sv ----
// host model: frames commands on the serial link, reads lane 1
`timescale 1ns/1ps
`default_nettype none
module snce_host (
	// link pins
	output logic       sck,
	output logic       cs_n,
	output logic [3:0] io_in,
	// device answer
	input  wire logic [3:0] io_out
);
	logic [7:0] rq[$];
	// idle: deselected, clock low (mode 0)
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		io_in = 4'hf;
	end
	// send bytes msb first on rising edges, then read nr bytes
	task automatic xf(input logic [7:0] tq[$], input int nr);
		logic [7:0] v;
		rq = {};
		cs_n = 1'b0;
		foreach (tq[i]) for (int k = 7; k >= 0; k--) begin
			io_in[0] = tq[i][k];
			#100 sck = 1'b1;
			#100 sck = 1'b0;
		end
		io_in[0] = ~io_in[0]; // inverted: no stale level
		repeat (nr) begin
			for (int k = 7; k >= 0; k--) begin
				#100 sck = 1'b1;
				#95 v[k] = io_out[1];
				#5 sck = 1'b0;
			end
			rq.push_back(v);
		end
		#100 cs_n = 1'b1;
		#200;
	endtask
endmodule
`default_nettype wire

// ---- bench/tb_snce_top.sv ----
// self-checking bench for the serial nand command engine
`timescale 1ns/1ps
`default_nettype none
module tb_snce_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sck, cs_n, seal, oe_seen;
	logic [3:0]  io_in, io_out, io_oe;
	logic [16:0] row;
	logic [7:0]  q[$];
	int miscompares = 0;
	int checks_done = 0;
	typedef struct { logic [7:0] a, d; logic wp; logic [7:0] e; } snce_row_s;
	snce_row_s rows[5] = '{'{8'ha0, 8'hbe, 1'b1, 8'hbe},
		'{8'ha0, 8'h80, 1'b0, 8'hbe}, '{8'ha0, 8'h00, 1'b1, 8'h00},
		'{8'hc0, 8'h03, 1'b1, 8'h00}, '{8'h90, 8'h00, 1'b1, 8'h00}};
	snce_host h (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));
	snce_top #(.PROG_CYC(20), .ERASE_CYC(40)) uut (.clk(clk),
		.rst_n(rst_n), .sck(sck), .cs_n(cs_n), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .row_address(row),
		.otp_seal_stored(1'b0), .otp_seal(seal));
	// clock and output-enable watch
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (io_oe !== 4'h0) oe_seen <= 1'b1;
	task automatic chk(input logic [23:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic stat(input logic [7:0] e, input logic [7:0] a);
		h.xf('{8'h0f, a}, 1);
		chk(h.rq[0], e);
	endtask
	task automatic idle;
		for (int n = 0; n < 100; n++) begin
			h.xf('{8'h0f, 8'hc0}, 1);
			if (h.rq[0][0] === 1'b0) return;
		end
		miscompares++;
		conclude();
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		stat(8'h01, 8'hc0);
		idle();
		stat(8'h10, 8'h90);
		stat(8'h00, 8'hb0);
		chk(seal, 1'b0);
		foreach (rows[i]) begin
			h.io_in[2] = rows[i].wp;
			// reserved bits of every row data byte stay zero
			h.xf('{8'h1f, rows[i].a, rows[i].d}, 0);
			h.io_in[2] = 1'b1;
			stat(rows[i].e, rows[i].a);
		end
		$display("feature rows done");
		h.xf('{8'hff}, 0);
		idle();
		stat(8'h00, 8'h90);
		h.xf('{8'h06}, 0);
		stat(8'h02, 8'hc0);
		h.xf('{8'h04}, 0);
		stat(8'h00, 8'hc0);
		h.xf('{8'hd8, 8'h00, 8'h00, 8'h40}, 0);
		stat(8'h00, 8'hc0);
		h.xf('{8'h06}, 0);
		h.xf('{8'hd8, 8'h00, 8'h00, 8'h40}, 0);
		idle();
		stat(8'h00, 8'hc0);
		h.xf('{8'h13, 8'h00, 8'h12, 8'h34}, 0);
		stat(8'h01, 8'hc0);
		chk(row, 17'h01234);
		idle();
		$display("latch and busy done");
		oe_seen = 1'b0;
		h.xf('{8'h9f, 8'h00}, 3);
		chk(oe_seen, 1'b1);
		chk({h.rq[0], h.rq[1], h.rq[2]}, 24'h5a3c5a);
		q = '{8'h02, 8'h00, 8'h00};
		for (int i = 0; i < 16; i++) q.push_back(8'(i * 17));
		h.xf(q, 0);
		h.xf('{8'h03, 8'hc0, 8'h0e, 8'h00}, 4);
		chk({h.rq[0], h.rq[1], h.rq[2]}, 24'heeff00);
		$display("read streams done");
		foreach (q[i]) if (i < 2) begin
			oe_seen = 1'b0;
			h.xf('{i ? 8'h6b : 8'h55, 8'h00, 8'h00, 8'h00}, 1);
			chk(oe_seen, 1'b0);
		end
		$display("refusals done");
		// lock row mapping, then a lock with bit 23 set is ignored
		h.xf('{8'h36, 8'h01, 8'h23, 8'h45}, 0);
		chk(row, 17'h00480);
		h.xf('{8'h36, 8'h80, 8'h00, 8'h00}, 0);
		chk(row, 17'h00480);
		$display("lock rows done");
		// reset in mid-run: latch dropped, page load again, ecc default
		h.xf('{8'h06}, 0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		stat(8'h01, 8'hc0);
		stat(8'h10, 8'h90);
		$display("mid-run reset done");
		conclude();
	end
endmodule
`default_nettype wire
